// ==== design/acsf_pkg.sv ====
// Purpose: constants and carrier types for the input/output slot formatter
// Assumes: frame of 256 link bits, tag slot 16 bits, twelve 20-bit slots
// Notes:   offsets count bits from the first tag bit of a frame
//
// Operation
// (RQ1) right playback: upper 16 of 20 bits
// (RQ2) right tag clear means sample is zero
// (RQ3) output slots 5 to 12 are ignored
// (RQ4) input frame: 16-bit tag, twelve 20-bit slots
// (RQ5) codec not ready zeroes whole input frame
// (RQ6) controller ignores frames without codec ready
// (RQ7) slow record rate: tags only with samples
// (RQ8) read answered next frame, both status tags
// (RQ9) no read: status tags and slots cleared
// (RQ10) unknown or odd index reads back zero
// (RQ11) status tags independent of request bits
// (RQ12) tag 11 equals tag 12; slot 4 zero
// (RQ13) touch lane tag forced when conversion enabled
// (RQ14) tag bits 8-4 and 2-0 zero
// (RQ15) frame start sampled falling, driven rising
// (RQ16) status index echoed, reserved bits zero
// (RQ17) slow playback rate: request low means send
// (RQ18) controller answers requests in next frame
// (RQ19) fixed rate holds request bits at zero
// (RQ20) read data appears once, next frame only
// (RQ21) record slot 3; powered down means zero
// (RQ22) touch slots: valid, mode, 12-bit result
// (RQ23) controller holds sync high sixteen bits
// (RQ24) link bit counter restarted by sync rise
package acsf_pkg;

  localparam int        FRAME_BITS   = 256;
  localparam int        RX_BITS      = 96;
  localparam logic [7:0] CNT_RESET   = 8'h00;
  localparam logic [7:0] CNT_RX_DONE = 8'h60;
  localparam logic [7:0] CNT_LAST    = 8'hFF;
  localparam logic [7:0] CNT_MSB     = 8'hFF;

  // tag bit positions and the slot 1 read command bit
  localparam int TAG_READY  = 15;
  localparam int TAG_ADDR   = 14;
  localparam int TAG_DATA   = 13;
  localparam int TAG_LEFT   = 12;
  localparam int TAG_RIGHT  = 11;
  localparam int TAG_TSC5   = 10;
  localparam int TAG_TSC6   = 9;
  localparam int TAG_TSC12  = 3;
  localparam int CMD_READ   = 19;

  // touch lane codes
  localparam logic [1:0] LANE_S5  = 2'h0;
  localparam logic [1:0] LANE_S6  = 2'h1;
  localparam logic [1:0] LANE_S12 = 2'h2;

  localparam logic [15:0] DATA_ZERO = 16'h0000;

  typedef struct packed {
    logic [15:0] tag;
    logic [19:0] slot1;
    logic [19:0] slot2;
    logic [19:0] slot3;
    logic [19:0] slot4;
  } acsf_rx_type;

  typedef struct packed {
    logic [15:0] tag;
    logic [19:0] slot1;
    logic [19:0] slot2;
    logic [19:0] slot3;
    logic [19:0] slot5;
    logic [19:0] slot6;
    logic [19:0] slot12;
  } acsf_tx_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ASK   = 3'b010,
    ST_BUILD = 3'b100
  } acsf_state_type;

endpackage : acsf_pkg

// ==== design/acsf_slot_formatter.sv ====
// Purpose: device-side slot formatter of the serial audio link
// Assumes: bit_clk is the link clock; sync and sdata_out change on its rising edge
// Notes:   frame words cross by toggle handshakes; core answers read in the same cycle as strobe
`timescale 1ns/1ns
module acsf_slot_formatter (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        bit_clk,
  input  wire logic        sync,
  input  wire logic        sdata_out,
  output logic             sdata_in,
  input  wire logic        codec_ready,
  input  wire logic        variable_rate_enable,
  input  wire logic        adc_power_down,
  input  wire logic        play_need_left,
  input  wire logic        play_need_right,
  input  wire logic [15:0] rec_sample,
  input  wire logic        rec_sample_strobe,
  input  wire logic        tsc_output_enable,
  input  wire logic [1:0]  tsc_convert_select,
  input  wire logic [1:0]  tsc_lane_select,
  input  wire logic        tsc_data_valid,
  input  wire logic [2:0]  tsc_measure_mode,
  input  wire logic [11:0] tsc_sample_value,
  input  wire logic [15:0] reg_read_data,
  input  wire logic        reg_read_known,
  output logic [6:0]       reg_read_index,
  output logic             reg_read_strobe,
  output logic [15:0]      play_right,
  output logic             play_right_strobe
);

  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------
  // read command present in a received frame
  function automatic logic acsf_is_read(input acsf_pkg::acsf_rx_type rx);
    acsf_is_read = rx.tag[acsf_pkg::TAG_READY] & rx.tag[acsf_pkg::TAG_ADDR] & rx.slot1[acsf_pkg::CMD_READ];
  endfunction : acsf_is_read

  // touch slot word: valid, mode, result, low nibble zero
  function automatic logic [19:0] acsf_tsc_word(input logic en, input logic v, input logic [2:0] m,
                                                input logic [11:0] d);
    acsf_tsc_word = en ? {v, m, d, 4'h0} : 20'h00000; // RQ22
  endfunction : acsf_tsc_word

  // -------------------------------------------------------------
  // link domain: reset and frame counter (falling edge)
  // -------------------------------------------------------------
  localparam int RX_W = acsf_pkg::RX_BITS;
  logic                  link_rst1_q;
  logic                  link_rst_b;
  logic                  sync_q;
  logic [7:0]            cnt_q;
  logic                  active_q;
  logic [RX_W-1:0]       rx_shift_q;
  acsf_pkg::acsf_rx_type rx_hold_q;
  logic                  rx_tgl_q;
  logic                  ack_s1_q;
  logic                  ack_s2_q;
  logic                  ack_s3_q;
  acsf_pkg::acsf_tx_type next_q;
  acsf_pkg::acsf_tx_type cur_q;
  logic                  sdata_in_q;
  // core-side payload and its toggle, read across by the link side
  acsf_pkg::acsf_tx_type tx_q;
  logic                  ack_tgl_q;

  wire frame_start = sync & ~sync_q;
  wire rx_shift_en = active_q & (cnt_q < acsf_pkg::CNT_RX_DONE);
  wire rx_latch    = active_q & (cnt_q == acsf_pkg::CNT_RX_DONE);
  wire ack_seen    = ack_s2_q ^ ack_s3_q;
  wire [7:0] cnt_inc = cnt_q + 8'h01;

  // reset brought into the link domain
  always_ff @(negedge bit_clk) begin
    link_rst1_q <= rst_b;
    link_rst_b  <= link_rst1_q;
  end

  // sync sampling and bit counter
  always_ff @(negedge bit_clk) begin
    if (!link_rst_b) begin
      sync_q   <= 1'b0;
      cnt_q    <= acsf_pkg::CNT_RESET;
      active_q <= 1'b0;
    end else begin
      sync_q <= sync;
      if (frame_start) begin
        cnt_q    <= acsf_pkg::CNT_RESET; // RQ24
        active_q <= 1'b1;                // RQ15
      end else if (active_q) begin
        cnt_q <= cnt_inc;
        if (cnt_q == acsf_pkg::CNT_LAST) begin
          active_q <= 1'b0;
        end
      end
    end
  end

  // receive shift: only tag and slots 1 to 4 are kept
  always_ff @(negedge bit_clk) begin
    if (!link_rst_b) begin
      rx_shift_q <= '0;
      rx_hold_q  <= '0;
      rx_tgl_q   <= 1'b0;
    end else begin
      if (rx_shift_en) begin
        rx_shift_q <= {rx_shift_q[RX_W-2:0], sdata_out}; // RQ3
      end
      if (rx_latch) begin
        rx_hold_q <= acsf_pkg::acsf_rx_type'(rx_shift_q);
        rx_tgl_q  <= ~rx_tgl_q;
      end
    end
  end

  // next frame payload picked up when the core acknowledges
  always_ff @(negedge bit_clk) begin
    if (!link_rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      next_q   <= '0;
      cur_q    <= '0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      if (ack_seen) begin
        next_q <= tx_q;
      end
      if (frame_start) begin
        cur_q <= next_q;
      end
    end
  end

  // -------------------------------------------------------------
  // link domain: transmit (rising edge)
  // -------------------------------------------------------------
  // slot 4 and slots 7 to 11 stay zero
  wire [acsf_pkg::FRAME_BITS-1:0] frame_vec = {cur_q.tag, cur_q.slot1, cur_q.slot2, cur_q.slot3,
                                               20'h00000, cur_q.slot5, cur_q.slot6, 100'h0,
                                               cur_q.slot12}; // RQ4 RQ12
  wire [7:0] tx_idx = acsf_pkg::CNT_MSB - cnt_q;
  wire       tx_bit = active_q & frame_vec[tx_idx];

  // bit k goes out on the rising edge after the counter shows k
  always_ff @(posedge bit_clk) begin
    if (!link_rst_b) begin
      sdata_in_q <= 1'b0;
    end else begin
      sdata_in_q <= tx_bit; // RQ15
    end
  end

  assign sdata_in = sdata_in_q;

  // -------------------------------------------------------------
  // core domain: frame handover
  // -------------------------------------------------------------
  logic                     rx_s1_q;
  logic                     rx_s2_q;
  logic                     rx_s3_q;
  acsf_pkg::acsf_state_type st_q;
  acsf_pkg::acsf_state_type st_d;
  acsf_pkg::acsf_rx_type    rx_q;
  acsf_pkg::acsf_tx_type    tx_d;
  logic                     rd_q;
  logic [6:0]               rd_index_q;
  logic                     rd_strobe_q;
  logic [15:0]              play_q;
  logic                     play_strobe_q;
  logic                     rec_pending_q;
  logic [15:0]              rec_q;

  wire rx_event  = rx_s2_q ^ rx_s3_q;
  wire rx_read   = acsf_is_read(rx_q);
  wire right_ok  = rx_q.tag[acsf_pkg::TAG_READY] & rx_q.tag[acsf_pkg::TAG_RIGHT];
  wire [15:0] right_w = right_ok ? rx_q.slot4[19:4] : acsf_pkg::DATA_ZERO; // RQ1 RQ2

  // state sequencing
  always_comb begin
    case (st_q)
      acsf_pkg::ST_IDLE:  st_d = rx_event ? acsf_pkg::ST_ASK : acsf_pkg::ST_IDLE;
      acsf_pkg::ST_ASK:   st_d = acsf_pkg::ST_BUILD;
      acsf_pkg::ST_BUILD: st_d = acsf_pkg::ST_IDLE;
      default:            st_d = acsf_pkg::ST_IDLE;
    endcase
  end

  // event synchroniser, frame capture and outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_s1_q       <= 1'b0;
      rx_s2_q       <= 1'b0;
      rx_s3_q       <= 1'b0;
      st_q          <= acsf_pkg::ST_IDLE;
      rx_q          <= '0;
      rd_q          <= 1'b0;
      rd_index_q    <= 7'h00;
      rd_strobe_q   <= 1'b0;
      play_q        <= acsf_pkg::DATA_ZERO;
      play_strobe_q <= 1'b0;
    end else begin
      rx_s1_q       <= rx_tgl_q;
      rx_s2_q       <= rx_s1_q;
      rx_s3_q       <= rx_s2_q;
      st_q          <= st_d;
      rd_strobe_q   <= 1'b0;
      play_strobe_q <= 1'b0;
      if ((st_q == acsf_pkg::ST_IDLE) && rx_event) begin
        rx_q <= rx_hold_q;
      end
      if (st_q == acsf_pkg::ST_ASK) begin
        rd_q          <= rx_read;           // RQ8
        rd_index_q    <= rx_q.slot1[18:12]; // RQ16
        rd_strobe_q   <= rx_read;
        play_q        <= right_w;           // RQ2
        play_strobe_q <= 1'b1;
      end
    end
  end

  assign reg_read_index    = rd_index_q;
  assign reg_read_strobe   = rd_strobe_q;
  assign play_right        = play_q;
  assign play_right_strobe = play_strobe_q;

  // -------------------------------------------------------------
  // core domain: input frame build
  // -------------------------------------------------------------
  wire build     = (st_q == acsf_pkg::ST_BUILD);
  wire rec_on    = ~adc_power_down;
  wire rec_valid = rec_on & (variable_rate_enable ? rec_pending_q : 1'b1); // RQ7 RQ21
  wire [1:0] req_bits = variable_rate_enable ? {~play_need_left, ~play_need_right} : 2'b00; // RQ17 RQ19
  wire odd_or_unknown = rd_index_q[0] | ~reg_read_known;
  wire [15:0] rd_data = odd_or_unknown ? acsf_pkg::DATA_ZERO : reg_read_data; // RQ10
  wire tsc_on   = tsc_output_enable & (tsc_convert_select != 2'h0);
  wire lane_s5  = tsc_output_enable & (tsc_lane_select == acsf_pkg::LANE_S5);
  wire lane_s6  = tsc_output_enable & ((tsc_lane_select == acsf_pkg::LANE_S5) |
                                       (tsc_lane_select == acsf_pkg::LANE_S6));
  wire lane_s12 = tsc_output_enable & (tsc_lane_select == acsf_pkg::LANE_S12);

  // payload assembly, all zero while the codec is not ready
  always_comb begin
    tx_d = '0;
    if (codec_ready) begin
      tx_d.tag[acsf_pkg::TAG_READY] = 1'b1;                               // RQ5
      tx_d.tag[acsf_pkg::TAG_ADDR]  = rd_q;                               // RQ8 RQ9 RQ11
      tx_d.tag[acsf_pkg::TAG_DATA]  = rd_q;                               // RQ8 RQ9 RQ11
      tx_d.tag[acsf_pkg::TAG_LEFT]  = rec_valid;                          // RQ21
      tx_d.tag[acsf_pkg::TAG_RIGHT] = rec_valid;                          // RQ12
      tx_d.tag[acsf_pkg::TAG_TSC5]  = tsc_on & (tsc_lane_select == acsf_pkg::LANE_S5);  // RQ13
      tx_d.tag[acsf_pkg::TAG_TSC6]  = tsc_on & (tsc_lane_select == acsf_pkg::LANE_S6);  // RQ13
      tx_d.tag[acsf_pkg::TAG_TSC12] = tsc_on & (tsc_lane_select == acsf_pkg::LANE_S12); // RQ13 RQ14
      tx_d.slot1 = {1'b0, (rd_q ? rd_index_q : 7'h00), req_bits, 10'h000}; // RQ16 RQ9
      tx_d.slot2 = rd_q ? {rd_data, 4'h0} : 20'h00000;                      // RQ20 RQ9
      tx_d.slot3 = rec_valid ? {rec_q, 4'h0} : 20'h00000;                  // RQ21
      tx_d.slot5  = acsf_tsc_word(lane_s5, tsc_data_valid, tsc_measure_mode, tsc_sample_value);
      tx_d.slot6  = acsf_tsc_word(lane_s6, tsc_data_valid, tsc_measure_mode, tsc_sample_value);
      tx_d.slot12 = acsf_tsc_word(lane_s12, tsc_data_valid, tsc_measure_mode, tsc_sample_value);
    end
  end

  // payload register, handshake toggle and record sample holding
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_q          <= '0;
      ack_tgl_q     <= 1'b0;
      rec_pending_q <= 1'b0;
      rec_q         <= acsf_pkg::DATA_ZERO;
    end else begin
      if (build) begin
        tx_q      <= tx_d; // RQ20
        ack_tgl_q <= ~ack_tgl_q;
      end
      if (rec_sample_strobe) begin
        rec_q         <= rec_sample;
        rec_pending_q <= 1'b1; // set wins over consumption
      end else if (build && codec_ready && rec_valid) begin
        rec_pending_q <= 1'b0; // RQ7
      end
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  not_ready_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ5
    !tx_q.tag[acsf_pkg::TAG_READY] |-> (tx_q == '0))
    else $error("frame not zero while codec not ready");

  status_tags_pair_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ9
    tx_q.tag[acsf_pkg::TAG_ADDR] == tx_q.tag[acsf_pkg::TAG_DATA])
    else $error("status tags differ");

  read_answer_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ8
    (rd_strobe_q && codec_ready && reg_read_known && !rd_index_q[0]) |=>
      (tx_q.tag[acsf_pkg::TAG_ADDR] && tx_q.slot2 == {$past(reg_read_data), 4'h0}
       && tx_q.slot1[18:12] == $past(rd_index_q)))
    else $error("read answer missing or wrong");

  read_once_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ20
    (st_q == acsf_pkg::ST_ASK && !rx_read) |-> ##2 (!tx_q.tag[acsf_pkg::TAG_ADDR] && tx_q.slot2 == 20'h00000))
    else $error("status data repeated without read");

  right_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ2
    (st_q == acsf_pkg::ST_ASK && !rx_q.tag[acsf_pkg::TAG_RIGHT]) |=> (play_right_strobe && play_right == 16'h0000))
    else $error("right sample not zeroed");

  tag_fill_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ14
    (tx_q.tag[8:4] == 5'h00) && (tx_q.tag[2:0] == 3'h0)
    && (tx_q.tag[acsf_pkg::TAG_RIGHT] == tx_q.tag[acsf_pkg::TAG_LEFT]))
    else $error("fixed tag bits wrong");

  index_echo_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ16
    !tx_q.slot1[19] && tx_q.slot1[9:0] == 10'h000 && (!tx_q.tag[acsf_pkg::TAG_ADDR] -> tx_q.slot1[18:12] == 7'h00))
    else $error("status address reserved bits wrong");

  fixed_rate_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ19
    (build && !variable_rate_enable) |=> tx_q.slot1[11:10] == 2'b00)
    else $error("request bits set at fixed rate");

  counter_start_a: assert property (@(negedge bit_clk) disable iff (!link_rst_b) // RQ24
    (sync && !sync_q) |=> (active_q && cnt_q == 8'h00) ##1 (cnt_q == 8'h01))
    else $error("bit counter not restarted");

  ready_first_a: assert property (@(posedge bit_clk) disable iff (!link_rst_b) // RQ15
    (active_q && cnt_q == 8'h00) |=> sdata_in_q == $past(cur_q.tag[acsf_pkg::TAG_READY]))
    else $error("codec ready bit not first");

endmodule : acsf_slot_formatter

// ==== tb/acsf_ctrl_model.sv ====
// Purpose: behavioural link controller facing the slot formatter
// Assumes: bit_clk runs free, frames back to back, 256 bits each
// Notes:   in_word holds the last complete input frame, first bit at the top
`timescale 1ns/1ns
module acsf_ctrl_model (
  input  wire logic                  bit_clk,
  input  wire logic                  run,
  input  wire acsf_pkg::acsf_rx_type out_frame,
  input  wire logic                  sdata_in,
  output logic                       sync,
  output logic                       sdata_out,
  output logic [255:0]               in_word,
  output logic [15:0]                frame_count
);
  logic [7:0]   pos_q = 8'hFF;
  logic [255:0] out_vec_q = '0;
  logic [255:0] in_vec_q = '0;
  wire  [7:0]   pos_d = pos_q + 8'h01;

  initial begin
    sync = 1'b0;
    sdata_out = 1'b0;
    in_word = '0;
    frame_count = 16'h0000;
  end

  // drive on rising edges; slots 5 to 12 carry a junk pattern
  always @(posedge bit_clk) begin
    if (!run) begin
      pos_q <= 8'hFF;
      sync <= 1'b0;
      sdata_out <= 1'b0;
    end else begin
      pos_q <= pos_d;
      sync <= (pos_d < 8'h10);
      if (pos_d == 8'h01) begin
        out_vec_q <= {out_frame, {8{20'hA5A5A}}};
        sdata_out <= out_frame[95];
      end else begin
        sdata_out <= out_vec_q[8'hFF - pos_q];
      end
    end
  end

  // sample device bits on falling edges
  always @(negedge bit_clk) begin
    if (run) begin
      in_vec_q[8'hFF - (pos_q - 8'h01)] <= sdata_in;
      if (pos_q == 8'h00) begin
        in_word <= {in_vec_q[255:1], sdata_in};
        frame_count <= frame_count + 16'h0001;
      end
    end
  end
endmodule : acsf_ctrl_model

// ==== tb/test_aclink_slot_formatter.sv ====
// Purpose: self-checking bench of the slot formatter against a link controller
// Assumes: answer to output frame N is checked in input frame N+1
// Notes:   core inputs change on core_clk falling edges
`timescale 1ns/1ns
module test_aclink_slot_formatter;
  logic                  core_clk = 1'b0;
  logic                  bit_clk = 1'b1;
  logic                  rst_b = 1'b0;
  logic                  run = 1'b0;
  logic                  sync, sdata_out, sdata_in, rd_stb, right_stb;
  logic                  rdy = 1'b0, vre = 1'b0, pd = 1'b0, need_l = 1'b0, need_r = 1'b0;
  logic                  rec_stb = 1'b0, ten = 1'b0, tv = 1'b0, rd_known = 1'b0;
  logic [15:0]           rec = 16'h0000, rd_data = 16'h0000, play_right, right_seen, frame_count;
  logic [1:0]            tcs = 2'h0, lane = 2'h0;
  logic [2:0]            tmode = 3'h0;
  logic [11:0]           tval = 12'h000;
  logic [6:0]            rd_idx, idx_seen;
  logic [255:0]          in_word;
  acsf_pkg::acsf_rx_type out_frame = '0;
  int                    n_mismatch = 0, checks_done = 0, n_reads = 0, cyc = 0;

  acsf_slot_formatter dut_u (.core_clk(core_clk), .rst_b(rst_b), .bit_clk(bit_clk), .sync(sync),
    .sdata_out(sdata_out), .sdata_in(sdata_in), .codec_ready(rdy), .variable_rate_enable(vre),
    .adc_power_down(pd), .play_need_left(need_l), .play_need_right(need_r), .rec_sample(rec),
    .rec_sample_strobe(rec_stb), .tsc_output_enable(ten), .tsc_convert_select(tcs),
    .tsc_lane_select(lane), .tsc_data_valid(tv), .tsc_measure_mode(tmode), .tsc_sample_value(tval),
    .reg_read_data(rd_data), .reg_read_known(rd_known), .reg_read_index(rd_idx),
    .reg_read_strobe(rd_stb), .play_right(play_right), .play_right_strobe(right_stb));
  acsf_ctrl_model ctrl_u (.bit_clk(bit_clk), .run(run), .out_frame(out_frame), .sdata_in(sdata_in),
    .sync(sync), .sdata_out(sdata_out), .in_word(in_word), .frame_count(frame_count));

  // clocks: link clock unrelated in phase
  always #5 core_clk = ~core_clk;
  always #24 bit_clk = ~bit_clk;

  // register file stand-in, answers on the falling edge inside the strobe cycle
  always @(negedge core_clk) begin
    if (rd_stb === 1'b1) begin
      rd_data <= rdat(rd_idx);
      rd_known <= (rd_idx < 7'h40);
    end
    if (cyc == 80000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // capture strobed outputs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (right_stb === 1'b1) right_seen <= play_right;
    if (rd_stb === 1'b1) begin
      n_reads <= n_reads + 1;
      idx_seen <= rd_idx;
    end
  end

  function automatic logic [15:0] rdat(input logic [6:0] i);
    return {~i, 2'h2, i};
  endfunction : rdat

  // expected input frame from the bench's own settings
  function automatic logic [255:0] exp_word(input logic rd, input logic [6:0] i, input logic rt);
    logic        on;
    logic [19:0] tp, s1, s2;
    on = ten && (tcs != 2'h0);
    tp = {tv, tmode, tval, 4'h0};
    s1 = {1'b0, rd ? i : 7'h00, vre & ~need_l, vre & ~need_r, 10'h000};
    s2 = (rd && !i[0] && i < 7'h40) ? {rdat(i), 4'h0} : 20'h00000;
    if (!rdy) return '0;
    return {1'b1, rd, rd, rt, rt, on && lane == 2'h0, on && lane == 2'h1, 5'h00, on && lane == 2'h2,
      3'h0, s1, s2, rt ? {rec, 4'h0} : 20'h00000, 20'h00000, (ten && lane == 2'h0) ? tp : 20'h00000,
      (ten && lane < 2'h2) ? tp : 20'h00000, 100'h0, (ten && lane == 2'h2) ? tp : 20'h00000};
  endfunction : exp_word

  function automatic logic [19:0] fld(input logic [255:0] w, input int k);
    if (k == 0) return {4'h0, w[255:240]};
    return w[259 - 20 * k -: 20];
  endfunction : fld

  task automatic chk(input string what, input logic [19:0] e, input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic wait_frame;
    @(frame_count);
    @(negedge core_clk);
  endtask : wait_frame

  task automatic pulse_rec(input logic [15:0] v);
    rec = v;
    rec_stb = 1'b1;
    @(negedge core_clk);
    rec_stb = 1'b0;
  endtask : pulse_rec

  // one output frame, its answer and the frame after it
  task automatic xact(input logic [15:0] ot, input logic [19:0] os1, input logic [15:0] r,
                      input logic rt, input logic [255:0] m);
    logic         rd, rf;
    int           r0;
    logic [255:0] ew;
    rd = ot[15] & ot[14] & os1[19];
    rf = rdy & ~pd & ~vre;
    r0 = n_reads;
    out_frame = {ot, os1, 20'h00000, 20'h13570, r, 4'h0};
    wait_frame();
    out_frame = '0;
    chk("right sample", {4'h0, ot[11] ? r : 16'h0000}, {4'h0, right_seen});
    chk("read strobes", 20'(n_reads - r0), {19'h0, rd});
    if (rd) chk("read index", {13'h0, os1[18:12]}, {13'h0, idx_seen});
    wait_frame();
    ew = exp_word(rd, os1[18:12], rt) & m;
    for (int k = 0; k < 13; k++) begin
      chk($sformatf("slot %0d", k), fld(ew, k), fld(in_word & m, k));
    end
    wait_frame();
    chk("follow tags", {16'h0, 2'b00, rf, rf}, {16'h0, in_word[254:251]});
    chk("follow data", 20'h00000, in_word[219:200]);
    $display("test done: tag %h slot1 %h", ot, os1);
  endtask : xact

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge core_clk);
    run = 1'b1;
    wait_frame();
    wait_frame();
    xact(16'hF800, {1'b1, 7'h1C, 12'h000}, 16'hBEEF, 1'b0, '1);
    rdy = 1'b1;
    pulse_rec(16'h8001);
    xact(16'hF800, {1'b1, 7'h1C, 12'h000}, 16'h8000, 1'b1, '1);
    xact(16'hF800, {1'b1, 7'h1D, 12'h000}, 16'h0001, 1'b1, '1);
    xact(16'hF800, {1'b1, 7'h52, 12'h000}, 16'hFFFF, 1'b1, '1);
    xact(16'hF800, {1'b0, 7'h1C, 12'h000}, 16'h4321, 1'b1, '1);
    xact(16'hF000, {1'b1, 7'h26, 12'h000}, 16'h7FFF, 1'b1, '1);
    vre = 1'b1;
    need_l = 1'b1;
    pulse_rec(16'h1234);
    xact(16'hF800, {1'b1, 7'h2A, 12'h000}, 16'h0F0F, 1'b1, '1);
    need_l = 1'b0;
    need_r = 1'b1;
    xact(16'h8800, 20'h00000, 16'hA55A, 1'b0, '1);
    vre = 1'b0;
    pd = 1'b1;
    xact(16'h8800, 20'h00000, 16'h0000, 1'b0, '1);
    pd = 1'b0;
    ten = 1'b1;
    tv = 1'b1;
    tmode = 3'h5;
    tval = 12'hA5C;
    for (int l = 0; l < 3; l++) begin
      lane = 2'(l);
      tcs = 2'(l + 1);
      xact(16'h8800, 20'h00000, 16'h5A5A, 1'b1, (l == 0) ? ~(256'h1 << 249) : '1);
    end
    stop_test();
  end
endmodule : test_aclink_slot_formatter
